// *** src/tnl_pkg.sv ***
// constants, field layout and helpers for the timing nco / agc limit bank
package tnl_pkg;

   localparam int unsigned ADDR_W   = 5;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned AGC_W    = 16;
   localparam int unsigned LIM_W    = 12;
   localparam int unsigned EXP_W    = 4;
   localparam int unsigned MANT_W   = 8;
   localparam int unsigned LIN_W    = 24;
   localparam int unsigned PHASE_W  = 8;

   // word addresses on the register port
   localparam logic [4:0] ADDR_AGC_LIMITS    = 5'h09;
   localparam logic [4:0] ADDR_AGC_SAMPLE    = 5'h0A;
   localparam logic [4:0] ADDR_NCO_CFG       = 5'h0B;
   localparam logic [4:0] ADDR_FREQ_HOLD     = 5'h0C;
   localparam logic [4:0] ADDR_PHASE_HOLD    = 5'h0D;
   localparam logic [4:0] ADDR_FREQ_STROBE   = 5'h0E;
   localparam logic [4:0] ADDR_PHASE_STROBE  = 5'h0F;
   localparam logic [4:0] ADDR_AGC_SAMPLE_RD = 5'h1A;

   // field positions
   localparam int unsigned LIM_MAX_LSB   = 16;
   localparam int unsigned LIM_MIN_LSB   = 0;
   localparam int unsigned LIM_EXP_LSB   = 8;
   localparam int unsigned CFG_SYNC_EN   = 5;
   localparam int unsigned CFG_WIDTH_LSB = 3;
   localparam int unsigned CFG_OFS_EN    = 2;
   localparam int unsigned CFG_CLR_ACC   = 1;
   localparam int unsigned CFG_LOAD_UPD  = 0;

   // writable bits of the limit and config words
   localparam logic [31:0] LIMITS_WMASK = 32'h0FFF_0FFF;
   localparam logic [31:0] CFG_WMASK    = 32'h0000_003F;

   // values after reset
   localparam logic [31:0] LIMITS_RST   = 32'h0000_0000;
   localparam logic [31:0] CFG_RST      = 32'h0000_0000;
   localparam logic [31:0] FREQ_RST     = 32'h0000_0000;
   localparam logic [7:0]  PHASE_RST    = 8'h00;
   localparam logic [15:0] SAMPLE_RST   = 16'h0000;
   localparam logic [23:0] GAIN_RST     = 24'h00_0000;

   // register port hit
   function automatic logic bus_hit(input logic       en,
                                    input logic [4:0] addr,
                                    input logic [4:0] target);
      return en && (addr == target);
   endfunction : bus_hit

   // limit word to linear gain 1.mmmmmmmm * 2^eeee, lsb = 2^-8
   function automatic logic [23:0] lim_to_lin(input logic [11:0] lim);
      logic [23:0] base;
      base = {15'h0000, 1'b1, lim[7:0]};
      return base << lim[11:8];
   endfunction : lim_to_lin

   // offset width code to msb-aligned mask
   function automatic logic [31:0] ofs_mask(input logic [1:0] code);
      logic [31:0] m;
      m = 32'hFFFF_FFFF;
      unique case (code)
         2'h0: m = 32'hFF00_0000;
         2'h1: m = 32'hFFFF_0000;
         2'h2: m = 32'hFFFF_FF00;
         2'h3: m = 32'hFFFF_FFFF;
      endcase
      return m;
   endfunction : ofs_mask

endpackage : tnl_pkg

// *** src/tnl_nco_if.sv ***
// control and status bundle between the bank and the timing nco core
`timescale 1ns/100ps
interface tnl_nco_if;
   logic [31:0] hold_freq;
   logic [7:0]  hold_phase;
   logic        freq_stb;
   logic        phase_stb;
   logic        sync_load;
   logic        load_upd;
   logic        clr_acc;
   logic        ofs_en;
   logic [1:0]  ofs_code;
   logic [31:0] ofs_in;
   logic [31:0] act_freq;
   logic [7:0]  act_phase;
   logic [31:0] acc;
   logic [7:0]  phase;

   modport ctrl (
      output hold_freq, hold_phase, freq_stb, phase_stb, sync_load,
             load_upd, clr_acc, ofs_en, ofs_code, ofs_in,
      input  act_freq, act_phase, acc, phase
   );
   modport nco (
      input  hold_freq, hold_phase, freq_stb, phase_stb, sync_load,
             load_upd, clr_acc, ofs_en, ofs_code, ofs_in,
      output act_freq, act_phase, acc, phase
   );
endinterface : tnl_nco_if

// *** src/tnl_sync_edge.sv ***
// external sync pin synchroniser with rising edge pulse
`timescale 1ns/100ps
module tnl_sync_edge (
   input  logic i_clk,
   input  logic i_arst_n,
   input  logic i_pin,
   output logic o_rise
);
   logic [2:0] sync_q;
   logic [2:0] sync_d;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   always_comb begin
      sync_d = {sync_q[1:0], i_pin};
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync_q <= 3'h0;
      end else begin
         sync_q <= sync_d;
      end
   end

   // stage 0 is read only by stage 1
   assign o_rise = sync_q[1] & ~sync_q[2];

   chk_sync_edge_delay: assert property (
      o_rise |-> $past(i_pin, 2) && !$past(i_pin, 3))
      else $error("sync pulse without a two stage delayed edge");
endmodule : tnl_sync_edge

// *** src/tnl_nco_core.sv ***
// timing nco active registers and phase accumulator
`timescale 1ns/100ps
module tnl_nco_core (
   input  logic  i_clk,
   input  logic  i_arst_n,
   tnl_nco_if.nco nco
);
   logic [31:0] act_freq_q,  act_freq_d;
   logic [7:0]  act_phase_q, act_phase_d;
   logic [31:0] acc_q,       acc_d;
   logic [7:0]  phase_q,     phase_d;
   logic [31:0] ofs_val;
   logic        load_f;
   logic        load_p;
   logic        zero_fb;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   always_comb begin
      load_f      = nco.freq_stb | nco.sync_load;
      load_p      = nco.phase_stb | nco.sync_load;
      zero_fb     = nco.clr_acc | (nco.load_upd & load_f);
      ofs_val     = 32'h0000_0000;
      if (nco.ofs_en) begin
         ofs_val = nco.ofs_in & tnl_pkg::ofs_mask(nco.ofs_code);
      end
      act_freq_d  = load_f ? nco.hold_freq : act_freq_q;
      act_phase_d = load_p ? nco.hold_phase : act_phase_q;
      acc_d       = (zero_fb ? 32'h0000_0000 : acc_q) + act_freq_q + ofs_val;
      // modulo add serves both offset readings
      phase_d     = acc_q[31:24] + act_phase_q;
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         act_freq_q  <= tnl_pkg::FREQ_RST;
         act_phase_q <= tnl_pkg::PHASE_RST;
         acc_q       <= tnl_pkg::FREQ_RST;
         phase_q     <= tnl_pkg::PHASE_RST;
      end else begin
         act_freq_q  <= act_freq_d;
         act_phase_q <= act_phase_d;
         acc_q       <= acc_d;
         phase_q     <= phase_d;
      end
   end

   assign nco.act_freq  = act_freq_q;
   assign nco.act_phase = act_phase_q;
   assign nco.acc       = acc_q;
   assign nco.phase     = phase_q;

   chk_acc_clear_zero: assert property (
      nco.clr_acc |=> acc_q == $past(act_freq_q) + $past(ofs_val))
      else $error("accumulator feedback not zeroed while clear set");
   chk_load_zero_fb: assert property (
      nco.sync_load && nco.load_upd
      |=> acc_q == $past(act_freq_q) + $past(ofs_val))
      else $error("sync load did not zero accumulator feedback");
   chk_acc_run: assert property (
      !zero_fb && !nco.ofs_en
      |=> acc_q == $past(acc_q) + $past(act_freq_q))
      else $error("accumulator step wrong with offset disabled");
   chk_ofs_width: assert property (
      nco.ofs_en && nco.ofs_code == 2'h0 |-> ofs_val[23:0] == 24'h00_0000)
      else $error("eight bit offset width leaks low bits");
   chk_hold_keep: assert property (
      !load_p |=> $stable(act_phase_q))
      else $error("active phase changed without a load");
endmodule : tnl_nco_core

// *** src/tnl_timing_nco_agc_limit_ctrl.sv ***
// control bank for agc gain limits, agc sampling and the timing nco
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module tnl_timing_nco_agc_limit_ctrl (
   input  logic        i_clk,
   input  logic        i_arst_n,
   input  logic [4:0]  i_addr,
   input  logic [31:0] i_wr_data,
   input  logic        i_wr_en,
   input  logic        i_rd_en,
   output logic [31:0] o_rd_data,
   input  logic        i_external_sync_input_b,
   input  logic [15:0] i_agc_loop_out,
   input  logic [31:0] i_offset_freq,
   output logic [3:0]  o_agc_max_exp,
   output logic [7:0]  o_agc_max_mant,
   output logic [3:0]  o_agc_min_exp,
   output logic [7:0]  o_agc_min_mant,
   output logic [23:0] o_agc_max_gain,
   output logic [23:0] o_agc_min_gain,
   output logic [15:0] o_agc_sample,
   output logic [31:0] o_nco_freq,
   output logic [7:0]  o_nco_phase_ofs,
   output logic [31:0] o_nco_acc,
   output logic [7:0]  o_nco_phase
);

   logic [31:0] limits_q,     limits_d;
   logic [31:0] cfg_q,        cfg_d;
   logic [31:0] freq_hold_q,  freq_hold_d;
   logic [7:0]  phase_hold_q, phase_hold_d;
   logic [15:0] sample_q,     sample_d;
   logic [23:0] max_gain_q,   max_gain_d;
   logic [23:0] min_gain_q,   min_gain_d;
   logic [31:0] rd_q,         rd_d;
   logic        wr_limits;
   logic        wr_sample;
   logic        wr_cfg;
   logic        wr_freq;
   logic        wr_phase;
   logic        wr_freq_stb;
   logic        wr_phase_stb;
   logic        sync_rise;

   tnl_nco_if nco_if ();

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   // write decode
   assign wr_limits    = tnl_pkg::bus_hit(i_wr_en, i_addr,
                                          tnl_pkg::ADDR_AGC_LIMITS);
   assign wr_sample    = tnl_pkg::bus_hit(i_wr_en, i_addr,
                                          tnl_pkg::ADDR_AGC_SAMPLE);
   assign wr_cfg       = tnl_pkg::bus_hit(i_wr_en, i_addr,
                                          tnl_pkg::ADDR_NCO_CFG);
   assign wr_freq      = tnl_pkg::bus_hit(i_wr_en, i_addr,
                                          tnl_pkg::ADDR_FREQ_HOLD);
   assign wr_phase     = tnl_pkg::bus_hit(i_wr_en, i_addr,
                                          tnl_pkg::ADDR_PHASE_HOLD);
   assign wr_freq_stb  = tnl_pkg::bus_hit(i_wr_en, i_addr,
                                          tnl_pkg::ADDR_FREQ_STROBE);
   assign wr_phase_stb = tnl_pkg::bus_hit(i_wr_en, i_addr,
                                          tnl_pkg::ADDR_PHASE_STROBE);

   // control words
   always_comb begin
      limits_d     = limits_q;
      cfg_d        = cfg_q;
      freq_hold_d  = freq_hold_q;
      phase_hold_d = phase_hold_q;
      if (wr_limits) begin
         limits_d = i_wr_data & tnl_pkg::LIMITS_WMASK;
      end
      if (wr_cfg) begin
         cfg_d = i_wr_data & tnl_pkg::CFG_WMASK;
      end
      if (wr_freq) begin
         freq_hold_d = i_wr_data;
      end
      if (wr_phase) begin
         phase_hold_d = i_wr_data[7:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         limits_q     <= tnl_pkg::LIMITS_RST;
         cfg_q        <= tnl_pkg::CFG_RST;
         freq_hold_q  <= tnl_pkg::FREQ_RST;
         phase_hold_q <= tnl_pkg::PHASE_RST;
      end else begin
         limits_q     <= limits_d;
         cfg_q        <= cfg_d;
         freq_hold_q  <= freq_hold_d;
         phase_hold_q <= phase_hold_d;
      end
   end

   // agc loop sample, frozen for multi-part reads
   always_comb begin
      sample_d = sample_q;
      if (wr_sample) begin
         sample_d = i_agc_loop_out;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sample_q <= tnl_pkg::SAMPLE_RST;
      end else begin
         sample_q <= sample_d;
      end
   end

   // linear limit gains for the agc clamp
   always_comb begin
      max_gain_d = tnl_pkg::lim_to_lin(
         limits_q[tnl_pkg::LIM_MAX_LSB +: tnl_pkg::LIM_W]);
      min_gain_d = tnl_pkg::lim_to_lin(
         limits_q[tnl_pkg::LIM_MIN_LSB +: tnl_pkg::LIM_W]);
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         max_gain_q <= tnl_pkg::GAIN_RST;
         min_gain_q <= tnl_pkg::GAIN_RST;
      end else begin
         max_gain_q <= max_gain_d;
         min_gain_q <= min_gain_d;
      end
   end

   // read data stands only in the cycle after the read strobe
   always_comb begin
      rd_d = 32'h0000_0000;
      if (i_rd_en) begin
         case (i_addr)
            tnl_pkg::ADDR_AGC_LIMITS: begin
               rd_d = limits_q;
            end
            tnl_pkg::ADDR_NCO_CFG: begin
               rd_d = cfg_q;
            end
            tnl_pkg::ADDR_FREQ_HOLD: begin
               rd_d = freq_hold_q;
            end
            tnl_pkg::ADDR_PHASE_HOLD: begin
               rd_d = {24'h00_0000, phase_hold_q};
            end
            tnl_pkg::ADDR_AGC_SAMPLE_RD: begin
               rd_d = {16'h0000, sample_q};
            end
            default: begin
               rd_d = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rd_q <= 32'h0000_0000;
      end else begin
         rd_q <= rd_d;
      end
   end

   tnl_sync_edge u_sync (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_pin    (i_external_sync_input_b),
      .o_rise   (sync_rise)
   );

   assign nco_if.hold_freq  = freq_hold_q;
   assign nco_if.hold_phase = phase_hold_q;
   assign nco_if.freq_stb   = wr_freq_stb;
   assign nco_if.phase_stb  = wr_phase_stb;
   assign nco_if.sync_load  = sync_rise & cfg_q[tnl_pkg::CFG_SYNC_EN];
   assign nco_if.load_upd   = cfg_q[tnl_pkg::CFG_LOAD_UPD];
   assign nco_if.clr_acc    = cfg_q[tnl_pkg::CFG_CLR_ACC];
   assign nco_if.ofs_en     = cfg_q[tnl_pkg::CFG_OFS_EN];
   assign nco_if.ofs_code   = cfg_q[tnl_pkg::CFG_WIDTH_LSB +: 2];
   assign nco_if.ofs_in     = i_offset_freq;

   tnl_nco_core u_nco (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .nco      (nco_if.nco)
   );

   assign o_rd_data       = rd_q;
   assign o_agc_max_exp   = limits_q[27:24];
   assign o_agc_max_mant  = limits_q[23:16];
   assign o_agc_min_exp   = limits_q[11:8];
   assign o_agc_min_mant  = limits_q[7:0];
   assign o_agc_max_gain  = max_gain_q;
   assign o_agc_min_gain  = min_gain_q;
   assign o_agc_sample    = sample_q;
   assign o_nco_freq      = nco_if.act_freq;
   assign o_nco_phase_ofs = nco_if.act_phase;
   assign o_nco_acc       = nco_if.acc;
   assign o_nco_phase     = nco_if.phase;

   sequence s_sample_wr;
      wr_sample;
   endsequence

   sequence s_cfg_rd;
      i_rd_en && (i_addr == tnl_pkg::ADDR_NCO_CFG);
   endsequence

   sequence s_limit_wr_settle;
      wr_limits ##1 !wr_limits;
   endsequence

   chk_sample_capture: assert property (
      s_sample_wr |=> o_agc_sample == $past(i_agc_loop_out))
      else $error("agc sample not captured on strobe write");

   chk_sample_hold_val: assert property (
      !wr_sample |=> $stable(o_agc_sample))
      else $error("agc sample moved without a strobe write");

   chk_limit_reserved: assert property (
      wr_limits |=> (limits_q & ~tnl_pkg::LIMITS_WMASK) == 32'h0000_0000)
      else $error("reserved limit bits were stored");

   chk_gain_decode: assert property (
      s_limit_wr_settle |=> o_agc_max_gain ==
         ({16'h0001, $past(limits_q[23:16])} << $past(limits_q[27:24])))
      else $error("max gain does not follow the limit word");

   chk_cfg_readback: assert property (
      s_cfg_rd |=> o_rd_data == $past(cfg_q))
      else $error("config readback wrong one cycle after read");

   chk_rd_idle_zero: assert property (
      !i_rd_en |=> o_rd_data == 32'h0000_0000)
      else $error("read data not zero outside the read answer");

   chk_sync_gate_off: assert property (
      !cfg_q[tnl_pkg::CFG_SYNC_EN] && !wr_freq_stb |=> $stable(o_nco_freq))
      else $error("active frequency moved with sync disabled");

   chk_freq_strobe: assert property (
      wr_freq_stb |=> o_nco_freq == $past(freq_hold_q))
      else $error("frequency strobe did not load the active word");

   chk_phase_strobe: assert property (
      wr_phase_stb |=> o_nco_phase_ofs == $past(phase_hold_q))
      else $error("phase strobe did not load the active offset");

   chk_min_gain_decode: assert property (
      s_limit_wr_settle |=> o_agc_min_gain ==
         ({16'h0001, $past(limits_q[7:0])} << $past(limits_q[11:8])))
      else $error("min gain does not follow the limit word");

   chk_sync_load_freq: assert property (
      nco_if.sync_load |=> o_nco_freq == $past(freq_hold_q))
      else $error("enabled sync did not load the active frequency");

   chk_sync_load_phase: assert property (
      nco_if.sync_load |=> o_nco_phase_ofs == $past(phase_hold_q))
      else $error("enabled sync did not load the active offset");

   chk_strobe_zero_fb: assert property (
      wr_freq_stb && cfg_q[tnl_pkg::CFG_LOAD_UPD] &&
      !cfg_q[tnl_pkg::CFG_OFS_EN] |=> o_nco_acc == $past(o_nco_freq))
      else $error("frequency strobe did not zero accumulator feedback");

   chk_cfg_reserved: assert property (
      wr_cfg |=> (cfg_q & ~tnl_pkg::CFG_WMASK) == 32'h0000_0000)
      else $error("reserved config bits were stored");

   chk_freq_hold_keep: assert property (
      !wr_freq_stb && !nco_if.sync_load |=> $stable(o_nco_freq))
      else $error("active frequency moved without strobe or sync");

   chk_sample_read: assert property (
      i_rd_en && (i_addr == tnl_pkg::ADDR_AGC_SAMPLE_RD)
      |=> o_rd_data == {16'h0000, $past(o_agc_sample)})
      else $error("sampled agc readback wrong");

endmodule : tnl_timing_nco_agc_limit_ctrl

// *** dv/tnl_sync_src.sv ***
// external sync source that drives the timing nco sync pin
`timescale 1ns/100ps
module tnl_sync_src (
   input  logic i_clk,
   input  logic i_go,
   output logic o_pin
);
   logic [1:0] cnt_q;

   initial cnt_q = 2'h0;

   // two cycles high, then at least two low before the next request
   always @(posedge i_clk) begin
      if (cnt_q != 2'h0) begin
         cnt_q <= cnt_q - 2'h1;
      end else if (i_go) begin
         cnt_q <= 2'h3;
      end
   end

   assign o_pin = cnt_q[1];
endmodule : tnl_sync_src

// *** dv/tnl_timing_nco_agc_limit_ctrl_tb.sv ***
// self-checking bench for the timing nco and agc limit bank
`timescale 1ns/100ps
`define CHK(got, exp) begin \
   cmp_count++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
   end \
end
module tnl_timing_nco_agc_limit_ctrl_tb;
   logic        i_clk, i_arst_n, i_wr_en, i_rd_en, sync_go, sync_pin;
   logic [4:0]  i_addr;
   logic [31:0] i_wr_data, o_rd_data, i_offset_freq, o_nco_freq, o_nco_acc;
   logic [15:0] i_agc_loop_out, o_agc_sample;
   logic [3:0]  o_agc_max_exp, o_agc_min_exp;
   logic [7:0]  o_agc_max_mant, o_agc_min_mant, o_nco_phase_ofs, o_nco_phase;
   logic [23:0] o_agc_max_gain, o_agc_min_gain;
   logic [31:0] seed;
   int          miscompares, cmp_count;

   tnl_timing_nco_agc_limit_ctrl u_tnl_timing_nco_agc_limit_ctrl (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
      .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
      .o_rd_data(o_rd_data), .i_external_sync_input_b(sync_pin),
      .i_agc_loop_out(i_agc_loop_out), .i_offset_freq(i_offset_freq),
      .o_agc_max_exp(o_agc_max_exp), .o_agc_max_mant(o_agc_max_mant),
      .o_agc_min_exp(o_agc_min_exp), .o_agc_min_mant(o_agc_min_mant),
      .o_agc_max_gain(o_agc_max_gain), .o_agc_min_gain(o_agc_min_gain),
      .o_agc_sample(o_agc_sample), .o_nco_freq(o_nco_freq),
      .o_nco_phase_ofs(o_nco_phase_ofs), .o_nco_acc(o_nco_acc),
      .o_nco_phase(o_nco_phase));

   tnl_sync_src u_tnl_sync_src (.i_clk(i_clk), .i_go(sync_go),
                                .o_pin(sync_pin));

   initial i_clk = 1'b0;
   always #5 i_clk = ~i_clk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // linear gain 1.mmmmmmmm shifted by the exponent, lsb 2^-8
   function automatic logic [23:0] gain(input logic [11:0] l);
      logic [31:0] b;
      b = {23'h00_0000, 1'b1, l[7:0]} << l[11:8];
      return b[23:0];
   endfunction : gain

   // offset kept from the top: 8, 16, 24 or 32 bits
   function automatic logic [31:0] wmask(input int c);
      return 32'hFFFF_FFFF << (24 - 8 * c);
   endfunction : wmask

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask : tick

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr_en <= 1'b1;
      i_addr <= a;
      i_wr_data <= d;
      @(posedge i_clk);
      i_wr_en <= 1'b0;
   endtask : wr

   task automatic chk_rd(input logic [4:0] a, input logic [31:0] e);
      @(posedge i_clk);
      i_rd_en <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd_en <= 1'b0;
      #1;
      `CHK(o_rd_data, e)
   endtask : chk_rd

   // accumulator advance over one clock
   task automatic step(input logic [31:0] e);
      logic [31:0] a;
      @(posedge i_clk);
      #1;
      a = o_nco_acc;
      @(posedge i_clk);
      #1;
      `CHK(o_nco_acc - a, e)
   endtask : step

   task automatic final_report();
      $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (5000) @(posedge i_clk);
      miscompares++;
      final_report();
   end

   initial begin
      logic [31:0] v, f1, f2, f3, p, q, ofs;
      seed = 32'h0000_0018;
      i_arst_n = 1'b0;
      i_wr_en = 1'b0;
      i_rd_en = 1'b0;
      i_addr = 5'h00;
      i_wr_data = 32'h0000_0000;
      i_agc_loop_out = 16'h0000;
      i_offset_freq = 32'h0000_0000;
      sync_go = 1'b0;
      tick(10);
      i_arst_n <= 1'b1;
      chk_rd(tnl_pkg::ADDR_AGC_LIMITS, tnl_pkg::LIMITS_RST);
      chk_rd(tnl_pkg::ADDR_NCO_CFG, tnl_pkg::CFG_RST);
      for (int i = 0; i < 3; i++) begin
         v = (i == 0) ? 32'hFFFF_FFFF : rnd();
         wr(tnl_pkg::ADDR_AGC_LIMITS, v);
         #1;
         `CHK(o_agc_max_exp, v[27:24])
         `CHK(o_agc_max_mant, v[23:16])
         `CHK({o_agc_min_exp, o_agc_min_mant}, v[11:0])
         tick(1);
         #1;
         `CHK(o_agc_max_gain, gain(v[27:16]))
         `CHK(o_agc_min_gain, gain(v[11:0]))
         chk_rd(tnl_pkg::ADDR_AGC_LIMITS, v & 32'h0FFF_0FFF);
      end
      tick(1);
      v = rnd();
      i_agc_loop_out <= v[15:0];
      wr(tnl_pkg::ADDR_AGC_SAMPLE, rnd());
      i_agc_loop_out <= ~v[15:0];
      #1;
      `CHK(o_agc_sample, v[15:0])
      tick(4);
      #1;
      `CHK(o_agc_sample, v[15:0])
      chk_rd(tnl_pkg::ADDR_AGC_SAMPLE_RD, {16'h0000, v[15:0]});
      chk_rd(tnl_pkg::ADDR_AGC_SAMPLE, 32'h0000_0000);
      f1 = rnd();
      p = rnd();
      wr(tnl_pkg::ADDR_FREQ_HOLD, f1);
      wr(tnl_pkg::ADDR_PHASE_HOLD, p);
      #1;
      `CHK(o_nco_freq, 32'h0000_0000)
      `CHK(o_nco_phase_ofs, 8'h00)
      chk_rd(tnl_pkg::ADDR_FREQ_HOLD, f1);
      chk_rd(tnl_pkg::ADDR_PHASE_HOLD, {24'h00_0000, p[7:0]});
      wr(tnl_pkg::ADDR_FREQ_STROBE, rnd());
      #1;
      `CHK(o_nco_freq, f1)
      wr(tnl_pkg::ADDR_PHASE_STROBE, rnd());
      #1;
      `CHK(o_nco_phase_ofs, p[7:0])
      tick(1);
      ofs = rnd();
      i_offset_freq <= ofs;
      for (int c = 0; c < 4; c++) begin
         wr(tnl_pkg::ADDR_NCO_CFG, 32'h0000_0004 | (c << 3));
         step(f1 + (ofs & wmask(c)));
      end
      wr(tnl_pkg::ADDR_NCO_CFG, 32'hFFFF_FFC0);
      step(f1);
      chk_rd(tnl_pkg::ADDR_NCO_CFG, 32'h0000_0000);
      wr(tnl_pkg::ADDR_NCO_CFG, 32'h0000_0002);
      tick(3);
      #1;
      `CHK(o_nco_acc, f1)
      `CHK(o_nco_phase, f1[31:24] + p[7:0])
      wr(tnl_pkg::ADDR_NCO_CFG, 32'h0000_0001);
      f2 = rnd();
      wr(tnl_pkg::ADDR_FREQ_HOLD, f2);
      wr(tnl_pkg::ADDR_FREQ_STROBE, 32'h0000_0000);
      #1;
      `CHK(o_nco_acc, f1)
      `CHK(o_nco_freq, f2)
      f3 = rnd();
      q = rnd();
      wr(tnl_pkg::ADDR_FREQ_HOLD, f3);
      wr(tnl_pkg::ADDR_PHASE_HOLD, q);
      sync_go <= 1'b1;
      tick(1);
      sync_go <= 1'b0;
      tick(8);
      #1;
      `CHK(o_nco_freq, f2)
      wr(tnl_pkg::ADDR_NCO_CFG, 32'h0000_0021);
      sync_go <= 1'b1;
      tick(1);
      sync_go <= 1'b0;
      tick(2);
      #1;
      `CHK(o_nco_freq, f2)
      tick(1);
      #1;
      `CHK(o_nco_freq, f3)
      `CHK(o_nco_acc, f2)
      `CHK(o_nco_phase_ofs, q[7:0])
      wr(5'h1F, rnd());
      chk_rd(5'h1F, 32'h0000_0000);
      chk_rd(tnl_pkg::ADDR_FREQ_STROBE, 32'h0000_0000);
      final_report();
   end
endmodule : tnl_timing_nco_agc_limit_ctrl_tb
